/* hdl/adc_readout_host.sv */
// Purpose: host end: clocks, frame reads, config writes, polling
// Assumes: one converter per instance, one chip select each
// Notes: frames land in a two-entry buffer toward the user
`timescale 1ns/100ps
`include "adc_readout_regs.svh"
`default_nettype none
module adc_readout_host
  import adc_readout_pkg::*;
#(
  parameter int unsigned WW = `WORD_W,
  parameter int unsigned FW = `FRAME_WORDS,
  parameter int unsigned MC_HALF = `MCLKIN_HALF,
  parameter int unsigned SCK_HALF = `SCLK_HALF,
  parameter int unsigned CS_SETUP = `CS_SETUP,
  parameter int unsigned CS_GAP = `CS_GAP,
  parameter int unsigned SYNC_LOW = `SYNC_LOW
) (
  input wire logic mclk,
  input wire logic rst,
  adc_link_if.host lnk,
  input wire logic cfg_valid,
  input wire logic [WW-1:0] cfg_data,
  output logic cfg_ready,
  input wire logic clr_resync_req,
  input wire logic sync_req,
  output logic [WW*FW-1:0] frame_data,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic poll_busy
);
  localparam int FB = WW * FW;
  localparam int BW = $clog2(FB + 1);
  localparam int MW = $clog2(MC_HALF + 1);
  localparam int SW = $clog2(SYNC_LOW + 1);
  localparam int TW = $clog2(CS_SETUP + SCK_HALF + CS_GAP + 1);

  function automatic logic [FB-1:0] cmd_frame(input logic [3:0] op, input logic [WW-1:0] pay);
    cmd_frame = {op, {(WW - 4){1'h0}}, pay, {(FB - 2 * WW){1'h0}}};
  endfunction

  // ****************************************
  // master clock and sync pulse
  // ****************************************
  logic [MW-1:0] mc_cnt_r;
  logic mc_r;
  logic [SW-1:0] sy_cnt_r;
  logic sync_n_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mc_cnt_r <= '0;
      mc_r <= 1'h0;
      sy_cnt_r <= '0;
      sync_n_r <= 1'h1;
    end else begin
      mc_cnt_r <= (mc_cnt_r == MW'(MC_HALF - 1)) ? '0 : mc_cnt_r + 1'h1;
      if (mc_cnt_r == MW'(MC_HALF - 1)) begin
        mc_r <= ~mc_r;
      end
      if (sync_req) begin
        sy_cnt_r <= SW'(SYNC_LOW);
      end else if (sy_cnt_r != '0) begin
        sy_cnt_r <= sy_cnt_r - 1'h1;
      end
      sync_n_r <= ~(sync_req | (sy_cnt_r > SW'(1)));
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
    end else begin
      s1_r <= {lnk.data_ready_n_pin, lnk.dout_line};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire logic data_ready_n_pin_fall;
  assign data_ready_n_pin_fall = ~s2_r[1] & s3_r[1];

  // ****************************************
  // frame engine
  // ****************************************
  host_state_t st_r;
  host_op_t op_r;
  logic [TW-1:0] tmr_r;
  logic [BW-1:0] bits_r;
  logic [FB-1:0] tx_r;
  logic [FB-1:0] rx_r;
  logic sclk_r;
  logic cs_n_r;
  logic seen_r;
  logic clr_pend_r;
  logic poll_r;
  logic push;
  logic [FB-1:0] head_r;
  logic [FB-1:0] tail_r;
  logic hv_r;
  logic tv_r;
  wire logic idle;
  wire logic take_clr;
  wire logic take_read;
  wire logic st_fault;
  assign idle = st_r == H_IDLE;
  assign take_clr = idle & ~cfg_valid & clr_pend_r;
  // a full buffer holds off reads; the converter keeps unread data
  assign take_read = idle & ~cfg_valid & ~clr_pend_r & ~poll_r & seen_r & ~tv_r;
  assign st_fault = rx_r[FB - WW + `ST_FAULT];
  assign push = (st_r == H_GAP) & (tmr_r == '0) & (op_r == OP_READ) & ~st_fault;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'h0;
      clr_pend_r <= 1'h0;
    end else begin
      seen_r <= data_ready_n_pin_fall | (seen_r & ~take_read);
      clr_pend_r <= clr_resync_req | (clr_pend_r & ~take_clr);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= H_IDLE;
      op_r <= OP_READ;
      tmr_r <= '0;
      bits_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      sclk_r <= 1'h0;
      cs_n_r <= 1'h1;
      poll_r <= 1'h0;
      cfg_ready <= 1'h0;
    end else begin
      cfg_ready <= 1'h0;
      case (st_r)
        H_IDLE: begin
          bits_r <= '0;
          tmr_r <= TW'(CS_SETUP - 1);
          if (cfg_valid) begin
            op_r <= OP_WREG;
            tx_r <= cmd_frame(`CMD_WREG, cfg_data);
            cfg_ready <= 1'h1;
          end else if (clr_pend_r) begin
            op_r <= OP_CLR;
            tx_r <= cmd_frame(`CMD_CLR_RESYNC, '0);
          end else if (poll_r) begin
            op_r <= OP_POLL;
            tx_r <= cmd_frame(`CMD_NULL, '0);
          end else begin
            op_r <= OP_READ;
            tx_r <= cmd_frame(`CMD_NULL, '0);
          end
          if (cfg_valid || clr_pend_r || poll_r || take_read) begin
            st_r <= H_SETUP;
            cs_n_r <= 1'h0;
          end
        end
        H_SETUP: begin
          tmr_r <= tmr_r - 1'h1;
          if (tmr_r == '0) begin
            tmr_r <= TW'(SCK_HALF - 1);
            st_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          tmr_r <= tmr_r - 1'h1;
          if (tmr_r == '0) begin
            tmr_r <= TW'(SCK_HALF - 1);
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              rx_r <= {rx_r[FB-2:0], s2_r[0]};
              tx_r <= {tx_r[FB-2:0], 1'h0};
              bits_r <= bits_r + 1'h1;
              if (bits_r == BW'(FB - 1)) begin
                cs_n_r <= 1'h1;
                tmr_r <= TW'(CS_GAP - 1);
                st_r <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          tmr_r <= tmr_r - 1'h1;
          if (tmr_r == '0) begin
            st_r <= H_IDLE;
            if (op_r == OP_WREG) begin
              poll_r <= 1'h1;
            end else if (op_r == OP_POLL && !st_fault) begin
              poll_r <= 1'h0;
            end
          end
        end
        default: begin
          st_r <= H_IDLE;
          cs_n_r <= 1'h1;
        end
      endcase
    end
  end

  // ****************************************
  // two-entry frame buffer
  // ****************************************
  wire logic pop;
  assign pop = hv_r & frame_ready;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      hv_r <= 1'h0;
      tv_r <= 1'h0;
    end else if (pop) begin
      head_r <= tv_r ? tail_r : rx_r;
      hv_r <= tv_r | push;
      tv_r <= tv_r & push;
      if (push) begin
        tail_r <= rx_r;
      end
    end else if (push && !hv_r) begin
      head_r <= rx_r;
      hv_r <= 1'h1;
    end else if (push) begin
      tail_r <= rx_r;
      tv_r <= 1'h1;
    end
  end

  assign frame_data = head_r;
  assign frame_valid = hv_r;
  assign poll_busy = poll_r;
  assign lnk.master_clock_input = mc_r;
  assign lnk.sclk = sclk_r;
  assign lnk.cs_n = cs_n_r;
  assign lnk.din = tx_r[FB-1];
  assign lnk.sync_reset_n = sync_n_r;

endmodule
`default_nettype wire

/* hdl/adc_readout_regs.svh */
// Purpose: shared constants for the converter readout link
// Assumes: 50 MHz mclk on both ends
// Notes: counts are in mclk cycles, except CONV_LEN and BARRIER_LEN, which are in master clocks
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH
// ****************************************
// frame layout
// ****************************************
`define WORD_W 16
`define FRAME_WORDS 3
`define ST_RESYNC 15
`define ST_FAULT 14
`define ST_PEND 13
`define CMD_HI 15
`define CMD_W 4
`define CMD_NULL 4'h0
`define CMD_CLR_RESYNC 4'h3
`define CMD_WREG 4'h6
// ****************************************
// timing
// ****************************************
`define CLK_NS 20
`define MCLKIN_NS 160
`define MCLKIN_HALF ((`MCLKIN_NS / `CLK_NS) / 2)
`define SCLK_HALF 8
`define CS_SETUP 16
`define CS_GAP 8
`define SYNC_LOW 8
`define CONV_LEN 64
`define BARRIER_LEN 32
`define DATA_READY_N_PIN_PULSE 8
`define SYNC_RST 5'h05
`endif

/* hdl/adc_readout_pkg.sv */
// Purpose: types shared by both ends of the readout link
// Assumes: nothing
// Notes: host states are gray coded along idle-setup-shift-gap
package adc_readout_pkg;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SETUP = 2'h1,
    H_SHIFT = 2'h3,
    H_GAP = 2'h2
  } host_state_t;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WREG = 2'h1,
    OP_POLL = 2'h2,
    OP_CLR = 2'h3
  } host_op_t;
endpackage

/* hdl/adc_link_if.sv */
// Purpose: pins between one converter and its host
// Assumes: one chip select per converter
// Notes: shared data-out line idles high when no converter drives it
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
  logic master_clock_input;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  logic data_ready_n_pin;
  logic sync_reset_n;
  assign dout_line = dout_oe ? dout : 1'h1;
  modport dev (
    input master_clock_input, sclk, cs_n, din, sync_reset_n,
    output dout, dout_oe, data_ready_n_pin
  );
  modport host (
    output master_clock_input, sclk, cs_n, din, sync_reset_n,
    input dout_line, data_ready_n_pin
  );
endinterface
`default_nettype wire

/* hdl/adc_readout_dev.sv */
// Purpose: converter-side readout, data-ready and status flags
// Assumes: link pins are asynchronous to mclk and slow against it
// Notes: conversion samples arrive on sample_in; no register map
`timescale 1ns/100ps
`include "adc_readout_regs.svh"
`default_nettype none
module adc_readout_dev
  import adc_readout_pkg::*;
#(
  parameter int unsigned WW = `WORD_W,
  parameter int unsigned FW = `FRAME_WORDS,
  parameter int unsigned CONV_LEN = `CONV_LEN,
  parameter int unsigned BARRIER_LEN = `BARRIER_LEN,
  parameter int unsigned DATA_READY_N_PIN_PULSE = `DATA_READY_N_PIN_PULSE
) (
  input wire logic mclk,
  input wire logic rst,
  adc_link_if.dev lnk,
  input wire logic ready_pulse_format,
  input wire logic [(FW-1)*WW-1:0] sample_in,
  output logic conv_tick,
  output logic resync_flag,
  output logic isolated_side_fault_flag,
  output logic frame_consumed
);
  localparam int FB = WW * FW;
  localparam int DW = (FW - 1) * WW;
  localparam int BW = $clog2(FB + 1);
  localparam int CW = $clog2(CONV_LEN);
  localparam int RW = $clog2(BARRIER_LEN + 1);
  localparam int PW = $clog2(DATA_READY_N_PIN_PULSE + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  wire logic [4:0] pins;
  assign pins = {lnk.master_clock_input, lnk.sclk, lnk.cs_n, lnk.din, lnk.sync_reset_n};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= `SYNC_RST;
      s2_r <= `SYNC_RST;
      s3_r <= `SYNC_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire logic mc_rise;
  wire logic sck_rise;
  wire logic sck_fall;
  wire logic cs_lo;
  wire logic cs_fall;
  wire logic din_s;
  wire logic sync_fall;
  assign mc_rise = s2_r[4] & ~s3_r[4];
  assign sck_rise = s2_r[3] & ~s3_r[3];
  assign sck_fall = ~s2_r[3] & s3_r[3];
  assign cs_lo = ~s2_r[2];
  assign cs_fall = ~s2_r[2] & s3_r[2];
  assign din_s = s2_r[1];
  assign sync_fall = ~s2_r[0] & s3_r[0];

  // ****************************************
  // conversion timing and sync check
  // ****************************************
  logic [CW-1:0] conv_cnt_r;
  wire logic conv_last;
  wire logic misalign;
  wire logic conv_now;
  // a sync edge away from the boundary realigns the count but never
  // fires a conversion of its own
  assign conv_last = conv_cnt_r == CW'(CONV_LEN - 1);
  assign misalign = sync_fall & (conv_cnt_r != '0);
  assign conv_now = mc_rise & conv_last & ~misalign;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_cnt_r <= '0;
    end else if (misalign) begin
      conv_cnt_r <= '0;
    end else if (mc_rise) begin
      conv_cnt_r <= conv_last ? '0 : conv_cnt_r + 1'h1;
    end
  end

  // ****************************************
  // serial frame
  // ****************************************
  logic [BW-1:0] bit_cnt_r;
  logic [WW-1:0] rx_r;
  logic [FB-1:0] sh_r;
  logic [DW-1:0] data_r;
  logic [WW-1:0] status_w;
  logic pending_r;
  logic fresh_r;
  logic dout_oe_r;
  wire logic bit_in;
  wire logic done_now;
  wire logic cmd_now;
  wire logic [WW-1:0] cmd_word;
  wire logic wreg_now;
  wire logic clr_now;

  assign bit_in = sck_rise & cs_lo;
  assign done_now = bit_in & (bit_cnt_r == BW'(FB - 1));
  assign cmd_now = bit_in & (bit_cnt_r == BW'(WW - 1));
  assign cmd_word = {rx_r[WW-2:0], din_s};
  assign wreg_now = cmd_now & (cmd_word[`CMD_HI -: `CMD_W] == `CMD_WREG);
  assign clr_now = cmd_now & (cmd_word[`CMD_HI -: `CMD_W] == `CMD_CLR_RESYNC);

  always_comb begin
    status_w = '0;
    status_w[`ST_RESYNC] = resync_flag;
    status_w[`ST_FAULT] = isolated_side_fault_flag;
    status_w[`ST_PEND] = pending_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= '0;
      rx_r <= '0;
    end else if (cs_fall) begin
      bit_cnt_r <= '0;
    end else if (bit_in && bit_cnt_r != BW'(FB)) begin
      bit_cnt_r <= bit_cnt_r + 1'h1;
      rx_r <= cmd_word;
    end
  end

  // whole frame is snapshotted at select so a conversion landing
  // mid-frame cannot tear the words being shifted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
    end else if (cs_fall) begin
      sh_r <= {status_w, data_r};
    end else if (sck_fall && cs_lo) begin
      sh_r <= {sh_r[FB-2:0], 1'h0};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_oe_r <= 1'h0;
    end else begin
      dout_oe_r <= cs_lo;
    end
  end

  assign lnk.dout = sh_r[FB-1];
  assign lnk.dout_oe = dout_oe_r;

  // ****************************************
  // output data update
  // ****************************************
  logic skip_r;
  wire logic skip_now;
  wire logic upd;
  // unread data in pulse format skips one refresh, halving the rate
  assign skip_now = ready_pulse_format & pending_r & ~skip_r;
  assign upd = conv_now & ~skip_now;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip_r <= 1'h0;
      data_r <= '0;
      conv_tick <= 1'h0;
    end else begin
      conv_tick <= conv_now;
      if (conv_now) begin
        skip_r <= skip_now;
      end
      if (upd) begin
        data_r <= sample_in;
      end
    end
  end

  // a frame only retires data it actually carried
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fresh_r <= 1'h0;
      pending_r <= 1'h0;
      frame_consumed <= 1'h0;
    end else begin
      if (upd) begin
        fresh_r <= 1'h0;
      end else if (cs_fall) begin
        fresh_r <= 1'h1;
      end
      if (upd) begin
        pending_r <= 1'h1;
      end else if (done_now && fresh_r) begin
        pending_r <= 1'h0;
      end
      frame_consumed <= done_now & fresh_r;
    end
  end

  // ****************************************
  // data-ready pin
  // ****************************************
  logic [PW-1:0] pc_r;
  logic gap_r;
  logic data_ready_n_pin_n_r;
  wire logic data_ready_n_pin_low;
  // level format drops a short high gap on overrun so every update
  // still shows as a falling edge
  assign data_ready_n_pin_low = ready_pulse_format ? (pc_r != '0) : (pending_r & ~gap_r);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_r <= '0;
      gap_r <= 1'h0;
      data_ready_n_pin_n_r <= 1'h1;
    end else begin
      if (upd) begin
        pc_r <= PW'(DATA_READY_N_PIN_PULSE);
        gap_r <= pending_r;
      end else if (pc_r != '0) begin
        pc_r <= pc_r - 1'h1;
        if (pc_r == PW'(1)) begin
          gap_r <= 1'h0;
        end
      end
      data_ready_n_pin_n_r <= ~data_ready_n_pin_low;
    end
  end

  assign lnk.data_ready_n_pin = data_ready_n_pin_n_r;

  // ****************************************
  // status flags
  // ****************************************
  logic [RW-1:0] bar_r;
  logic [RW-1:0] bar_nxt;
  // the barrier copy runs on the master clock, so the fault time
  // scales with that clock rather than mclk
  always_comb begin
    bar_nxt = bar_r;
    if (wreg_now) begin
      bar_nxt = RW'(BARRIER_LEN);
    end else if (mc_rise && bar_r != '0) begin
      bar_nxt = bar_r - 1'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bar_r <= '0;
      isolated_side_fault_flag <= 1'h0;
      resync_flag <= 1'h0;
    end else begin
      bar_r <= bar_nxt;
      isolated_side_fault_flag <= bar_nxt != '0;
      resync_flag <= misalign | (resync_flag & ~clr_now);
    end
  end

endmodule
`default_nettype wire

/* test/adc_readout_checker.sv */
// Purpose: pin-level checks on the link between converter and host
// Assumes: one mclk domain, rst asynchronous active high
// Notes: sees only the link signals, so format-dependent timing is left to the bench
`timescale 1ns/100ps
`default_nettype none
module adc_readout_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic master_clock_input,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line,
  input wire logic data_ready_n_pin,
  input wire logic sync_reset_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ****************************************
  // sclk rises seen inside one frame
  // ****************************************
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;
  logic sclk_q_r;
  assign rise_cnt_nxt = cs_n ? 6'h00 : (sclk && !sclk_q_r) ? rise_cnt_r + 6'h01 : rise_cnt_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rise_cnt_r <= 6'h00;
      sclk_q_r <= 1'h0;
    end else begin
      rise_cnt_r <= rise_cnt_nxt;
      sclk_q_r <= sclk;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_frame_all_words: assert property ($rose(cs_n) |-> rise_cnt_r == 6'h30)
    else $error("frame closed without 48 clock rises");
  a_dout_released: assert property (cs_n [*5] |-> !dout_oe && dout_line)
    else $error("data-out driven while deselected");
  a_dout_on_select: assert property ($fell(cs_n) |-> ##[2:5] dout_oe)
    else $error("data-out not driven after select");
  a_sync_width: assert property ($fell(sync_reset_n) |=> !sync_reset_n [*7] ##1 sync_reset_n)
    else $error("sync pulse width wrong");
  a_mclk_divide: assert property ($changed(master_clock_input) |=>
    $stable(master_clock_input) [*3] ##1 $changed(master_clock_input))
    else $error("master clock not mclk divided by 8");
  a_ready_low_min: assert property ($fell(data_ready_n_pin) |=> !data_ready_n_pin [*7])
    else $error("data-ready low too short");
  a_din_steady: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("din moved while sclk high");
  a_dout_steady: assert property (!cs_n && sclk && $past(sclk) |-> $stable(dout_line))
    else $error("data-out moved while sclk high");
  a_sclk_quiet: assert property (cs_n |-> !sclk)
    else $error("sclk active while deselected");
  a_line_follows: assert property (dout_oe |-> dout_line == dout)
    else $error("shared line does not carry data-out");
  c_frame: cover property ($rose(cs_n));
  c_sync: cover property ($fell(sync_reset_n));
  c_ready: cover property ($fell(data_ready_n_pin));
endmodule
`default_nettype wire

/* test/test_isolated_adc_readout_status.sv */
// Purpose: both link ends joined, driven from their user sides, judged there and at the link pins
// Assumes: conversion lengthened to 128 master clocks, barrier shortened to 4
// Notes: 128 keeps a whole read inside one conversion period
`timescale 1ns/100ps
`default_nettype none
module test_isolated_adc_readout_status
  import adc_readout_pkg::*;
;
  localparam int CONV_CYC = 1024;
  logic mclk, rst, fmt, cfg_valid, cfg_ready, clr_req, sync_req;
  logic frame_valid, frame_ready, poll_busy, conv_tick, resync_flag;
  logic isolated_side_fault_flag, frame_consumed;
  logic [15:0] cfg_data;
  logic [31:0] sample;
  logic [47:0] frame_data;
  int err_total, checks_done, cyc, consumed, pops;
  adc_link_if lnk();
  adc_readout_host u_adc_readout_host (.mclk(mclk), .rst(rst), .lnk(lnk), .cfg_valid(cfg_valid),
    .cfg_data(cfg_data), .cfg_ready(cfg_ready), .clr_resync_req(clr_req), .sync_req(sync_req),
    .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .poll_busy(poll_busy));
  adc_readout_dev #(.CONV_LEN(128), .BARRIER_LEN(4)) u_adc_readout_dev (.mclk(mclk), .rst(rst),
    .lnk(lnk), .ready_pulse_format(fmt), .sample_in(sample), .conv_tick(conv_tick),
    .resync_flag(resync_flag), .isolated_side_fault_flag(isolated_side_fault_flag),
    .frame_consumed(frame_consumed));
  adc_readout_checker u_adc_readout_checker (.mclk(mclk), .rst(rst),
    .master_clock_input(lnk.master_clock_input), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .din(lnk.din), .dout(lnk.dout), .dout_oe(lnk.dout_oe), .dout_line(lnk.dout_line),
    .data_ready_n_pin(lnk.data_ready_n_pin), .sync_reset_n(lnk.sync_reset_n));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // counted between edges: rising-edge outputs have settled and a
  // frame_ready change made on the falling edge has landed
  always @(negedge mclk) begin
    #5;
    if (frame_consumed === 1'h1) consumed++;
    if (frame_valid === 1'h1 && frame_ready === 1'h1) pops++;
  end
  // a hang is cut short well past the expected 19k cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("BAD timeout expected %0d seen %0d", 0, cyc);
      test_done();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic wait_fall(output int n);
    logic p;
    p = 1'h0;
    n = 0;
    while (n < 5000 && !(p === 1'h1 && lnk.data_ready_n_pin === 1'h0)) begin
      p = lnk.data_ready_n_pin;
      @(negedge mclk);
      n++;
    end
  endtask
  // sync well away from a conversion boundary, so the count is not zero
  task automatic sync_mid;
    int n;
    for (n = 0; n < 2000 && conv_tick !== 1'h1; n++) @(negedge mclk);
    repeat (100) @(negedge mclk);
    sync_req = 1'h1;
    @(negedge mclk);
    sync_req = 1'h0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_read;
    int n, c0;
    c0 = consumed;
    wait_fall(n);
    for (n = 0; n < 3000 && frame_valid !== 1'h1; n++) @(negedge mclk);
    chk("channel words", 48'(sample), 48'(frame_data[31:0]));
    chk("data-ready after read", 48'h1, 48'(lnk.data_ready_n_pin));
    chk("frames retired", 48'(c0 + 1), 48'(consumed));
    $display("test_read done");
  endtask
  task automatic test_cfg;
    int n;
    sample = 32'h5a5a0f0f;
    cfg_data = 16'h00a5;
    cfg_valid = 1'h1;
    for (n = 0; n < 3000 && cfg_ready !== 1'h1; n++) @(negedge mclk);
    cfg_valid = 1'h0;
    for (n = 0; n < 1000 && isolated_side_fault_flag !== 1'h1; n++) @(negedge mclk);
    chk("fault set", 48'h1, 48'(isolated_side_fault_flag));
    for (n = 0; n < 200 && isolated_side_fault_flag === 1'h1; n++) @(negedge mclk);
    chk("fault hold", 48'h1, 48'(n >= 24 && n <= 33));
    for (n = 0; n < 2000 && poll_busy !== 1'h1; n++) @(negedge mclk);
    chk("polling", 48'h1, 48'(poll_busy));
    for (n = 0; n < 4000 && poll_busy !== 1'h0; n++) @(negedge mclk);
    for (n = 0; n < 3000 && frame_valid !== 1'h1; n++) @(negedge mclk);
    chk("frame fault bit", 48'h0, 48'(frame_data[46]));
    chk("fresh channel words", 48'h5a5a0f0f, 48'(frame_data[31:0]));
    $display("test_cfg done");
  endtask
  task automatic test_resync;
    int n;
    sync_mid();
    for (n = 0; n < 2000 && conv_tick !== 1'h1; n++) @(negedge mclk);
    chk("realigned", 48'h1, 48'(n > 1000 && n < 1050));
    chk("resync set", 48'h1, 48'(resync_flag));
    clr_req = 1'h1;
    @(negedge mclk);
    clr_req = 1'h0;
    for (n = 0; n < 3000 && resync_flag !== 1'h0; n++) @(negedge mclk);
    chk("resync cleared", 48'h0, 48'(resync_flag));
    sync_mid();
    repeat (40) @(negedge mclk);
    chk("resync again", 48'h1, 48'(resync_flag));
    $display("test_resync done");
  endtask
  task automatic test_rate;
    int n, p0;
    fmt = 1'h1;
    wait_fall(n);
    wait_fall(n);
    wait_fall(n);
    chk("full rate gap", 48'(CONV_CYC), 48'(n));
    frame_ready = 1'h0;
    repeat (5 * CONV_CYC) @(negedge mclk);
    wait_fall(n);
    wait_fall(n);
    chk("half rate gap", 48'(2 * CONV_CYC), 48'(n));
    p0 = pops;
    frame_ready = 1'h1;
    repeat (20) @(negedge mclk);
    chk("buffered frames", 48'(p0 + 2), 48'(pops));
    chk("buffer empty", 48'h0, 48'(frame_valid));
    fmt = 1'h0;
    $display("test_rate done");
  endtask
  initial begin
    rst = 1'h1;
    fmt = 1'h0;
    cfg_valid = 1'h0;
    cfg_data = 16'h0000;
    clr_req = 1'h0;
    sync_req = 1'h0;
    frame_ready = 1'h1;
    sample = 32'h1234abcd;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    consumed = 0;
    pops = 0;
    repeat (6) @(negedge mclk);
    rst = 1'h0;
    chk("idle pins", 48'h7, 48'({lnk.cs_n, lnk.data_ready_n_pin, lnk.sync_reset_n}));
    test_read();
    test_cfg();
    test_resync();
    test_rate();
    test_done();
  end
endmodule
`default_nettype wire
